// *** bench/rss_host_model.sv ***
module rss_host_model
(
    input wire logic clk, // Reference clock
    output logic sck, // Serial clock
    output logic csLow, // Frame select
    output logic mosi, // Data to device
    input wire logic misoOut, // Device data
    input wire logic misoOeLow // Low while device drives
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lastBit = 1'b0;
    logic misoLine;
    // A released line toggles, so a stale bit is never mistaken for data.
    assign misoLine = misoOeLow ? ~lastBit : misoOut;
    always_ff @(posedge clk)
        lastBit <= misoLine;
    initial
    begin
        sck = 1'b0;
        csLow = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk);
        csLow <= 1'b0;
        repeat (14) @(posedge clk);
        for (int i = 15; i > 15 - n; i--)
        begin
            sck <= 1'b1;
            mosi <= tx[i];
            // The high phase is the longer one: the device needs four clocks to move MISO.
            repeat (5) @(posedge clk);
            sck <= 1'b0;
            rx[i] = misoLine;
            repeat (3) @(posedge clk);
        end
        // Keeps half a serial period between the last falling edge and deselect.
        @(posedge clk);
        csLow <= 1'b1;
        repeat (16) @(posedge clk);
    endtask
endmodule // rss_host_model

// *** bench/rss_spi_slave_assertions.sv ***
module rss_spi_slave_checker
    import rss_pkg::*;
#(
    parameter longint PonCycles = PON_CYCLES
)
(
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic serialClk, // Serial clock
    input wire logic chipSelectLow, // Frame select
    input wire logic misoOut, // Data out
    input wire logic misoOeLow, // Out enable
    input wire logic [13:0] zeroPosHi, // Register
    input wire logic [13:0] zeroPosLo, // Register
    input wire logic [13:0] settings1, // Register
    input wire logic [13:0] settings2, // Register
    input wire logic [13:0] redundancy, // Register
    input wire logic [13:0] progCtrl, // Register
    input wire logic [2:0] errorFlags, // Errors
    input wire logic dataValid // Valid
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cnt;
    // Saturates so a long run cannot wrap and fake an early valid.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt <= 32'h0;
        else if (cnt < 32'hFFFFFFF0)
            cnt <= cnt + 32'h1;
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    AST_OE_REL: assert property (chipSelectLow [*5] |-> misoOeLow)
        else $error("MISO driven while deselected");
    AST_OE_SEL: assert property (!misoOeLow |-> !chipSelectLow || !$past(chipSelectLow, 5))
        else $error("MISO enable outside frame");
    AST_REG_HOLD: assert property ($changed({zeroPosHi, zeroPosLo, settings1, settings2,
        redundancy, progCtrl}) |-> chipSelectLow)
        else $error("Register changed inside frame");
    AST_ERR_HOLD: assert property ($changed(errorFlags) |-> chipSelectLow)
        else $error("Error flags changed inside frame");
    AST_MISO_STABLE: assert property (!serialClk && $past(!serialClk) && !misoOeLow
        && $past(!misoOeLow, 3) |-> $stable(misoOut))
        else $error("MISO moved while clock low");
    AST_PON_EARLY: assert property (dataValid |-> longint'(cnt) >= PonCycles - 1)
        else $error("Valid raised too early");
    AST_PON_LATE: assert property (longint'(cnt) >= PonCycles + 2 |-> dataValid)
        else $error("Valid not raised in time");
    AST_VALID_KEEP: assert property ($past(dataValid) |-> dataValid)
        else $error("Valid dropped");
endmodule // rss_spi_slave_checker

bind rss_spi_slave rss_spi_slave_checker #(.PonCycles(PonCycles)) u_chk (.ref_clk, .rst,
    .serialClk, .chipSelectLow, .misoOut, .misoOeLow, .zeroPosHi, .zeroPosLo, .settings1,
    .settings2, .redundancy, .progCtrl, .errorFlags, .dataValid);

// *** bench/rss_spi_slave_bench.sv ***
module rss_spi_slave_bench
    import rss_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam longint PonBench = 20;
    typedef struct {logic wr; logic [13:0] a; logic [13:0] d; logic [13:0] o;} rss_row_s;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sck, csLow, mosi, misoOut, misoOeLow, dataValid;
    logic [13:0] zph, zpl, st1, st2, red, prg;
    logic [2:0] errorFlags;
    logic [15:0] rx;
    rss_sense_s sense = '{14'h1234, 14'h0ABC, 14'h2DEF, 14'h0180};
    int errorCnt = 0;
    int testsRun = 0;
    rss_row_s rows [12] = '{
        '{1'b0, ADDR_ANG_COMP, 14'h1234, 14'h0000},
        '{1'b0, ADDR_ANG_RAW, 14'h0ABC, 14'h0000},
        '{1'b0, ADDR_MAGN, 14'h2DEF, 14'h0000},
        '{1'b0, ADDR_DIAG, 14'h0180, 14'h0000},
        '{1'b0, ADDR_SET1, 14'h0001, 14'h0000},
        '{1'b1, ADDR_SET1, 14'h3FFF, 14'h0001},
        '{1'b1, ADDR_ZPOS_HI, 14'h00A5, 14'h0000},
        '{1'b1, ADDR_ZPOS_LO, 14'h0015, 14'h0000},
        '{1'b1, ADDR_SET2, 14'h2AAA, 14'h0000},
        '{1'b1, ADDR_REDUND, 14'h1555, 14'h0000},
        '{1'b1, ADDR_PROG, 14'h0041, 14'h0000},
        '{1'b0, ADDR_ZPOS_HI, 14'h00A5, 14'h0000}
    };
    always #12.5 ref_clk = ~ref_clk;
    rss_spi_slave #(.PonCycles(PonBench)) u_dut (.ref_clk(ref_clk), .rst(rst), .serialClk(sck),
        .chipSelectLow(csLow), .mosi(mosi), .misoOut(misoOut), .misoOeLow(misoOeLow), .sense(sense),
        .zeroPosHi(zph), .zeroPosLo(zpl), .settings1(st1), .settings2(st2), .redundancy(red),
        .progCtrl(prg), .errorFlags(errorFlags), .dataValid(dataValid));
    rss_host_model u_host (.clk(ref_clk), .sck(sck), .csLow(csLow), .mosi(mosi),
        .misoOut(misoOut), .misoOeLow(misoOeLow));
    function automatic logic [15:0] mk(input logic b, input logic [13:0] d);
        return {^{b, d}, b, d};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic fr(input logic [15:0] tx);
        u_host.xfer(tx, 16, rx);
    endtask
    task automatic endOfTest;
        $display("Checks %0d, errors %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        chk("oe", 16'h1, 16'(misoOeLow));
        chk("set1", 16'h1, 16'(st1));
        chk("zero", 16'h0, 16'(zph | zpl | st2 | red | prg | 14'(errorFlags)));
        chk("valid", 16'h0, 16'(dataValid));
        repeat (PonBench + 4) @(posedge ref_clk);
        chk("valid", 16'h1, 16'(dataValid));
        foreach (rows[k])
        begin
            fr(mk(!rows[k].wr, rows[k].a));
            if (rows[k].wr)
            begin
                fr(mk(1'b0, rows[k].d));
                chk("old", mk(1'b0, rows[k].o), rx);
            end
            fr(mk(1'b1, ADDR_NOP));
            chk("reply", mk(1'b0, rows[k].d), rx);
        end
        chk("set1", 16'h3FFF, 16'(st1));
        chk("zlo", 16'h0015, 16'(zpl));
        chk("set2", 16'h2AAA, 16'(st2));
        chk("red", 16'h1555, 16'(red));
        chk("prog", 16'h0041, 16'(prg));
        fr(mk(1'b1, 14'h0002));
        chk("inv", 16'h2, 16'(errorFlags));
        fr(mk(1'b1, ADDR_NOP));
        chk("errbit", 16'h1, 16'(rx[14]));
        chk("rpar", 16'h0, 16'(^rx));
        fr(mk(1'b1, ADDR_SET1) ^ 16'h8000);
        chk("perr", 16'h6, 16'(errorFlags));
        u_host.xfer(mk(1'b1, ADDR_NOP), 8, rx);
        chk("ferr", 16'h7, 16'(errorFlags));
        fr(mk(1'b0, ADDR_SET2));
        fr(mk(1'b1, 14'h0123));
        chk("set2", 16'h2AAA, 16'(st2));
        fr(mk(1'b1, ADDR_ERRFLAGS));
        fr(mk(1'b1, ADDR_NOP));
        chk("errreg", 16'h0007, 16'(rx[13:0]));
        chk("clr", 16'h0, 16'(errorFlags));
        endOfTest;
    end
    initial
    begin
        #1000000;
        errorCnt++;
        endOfTest;
    end
endmodule // rss_spi_slave_bench

// *** inc/rss_pkg.sv ***
package rss_pkg;

    localparam int FRAME_BITS = 16;
    localparam int PAR_BIT = 15;
    localparam int DIR_BIT = 14;
    localparam int ADDR_W = 14;
    localparam int CNT_W = 5;

    localparam logic [13:0] ADDR_NOP = 14'h0000;
    localparam logic [13:0] ADDR_ERRFLAGS = 14'h0001;
    localparam logic [13:0] ADDR_PROG = 14'h0003;
    localparam logic [13:0] ADDR_ZPOS_HI = 14'h0016;
    localparam logic [13:0] ADDR_ZPOS_LO = 14'h0017;
    localparam logic [13:0] ADDR_SET1 = 14'h0018;
    localparam logic [13:0] ADDR_SET2 = 14'h0019;
    localparam logic [13:0] ADDR_REDUND = 14'h001A;
    localparam logic [13:0] ADDR_DIAG = 14'h3FFC;
    localparam logic [13:0] ADDR_MAGN = 14'h3FFD;
    localparam logic [13:0] ADDR_ANG_RAW = 14'h3FFE;
    localparam logic [13:0] ADDR_ANG_COMP = 14'h3FFF;

    localparam logic [13:0] RST_SET1 = 14'h0001;
    localparam logic [13:0] RST_ZERO = 14'h0000;

    localparam int ERR_PARITY = 2;
    localparam int ERR_INVALID = 1;
    localparam int ERR_FRAMING = 0;

    // Power-on valid time and its cycle count at the 40 MHz reference clock.
    localparam longint CLK_HZ = 40000000;
    localparam longint PON_MS = 10;
    localparam longint PON_CYCLES = (PON_MS * CLK_HZ) / 1000;

    typedef struct packed {
        logic parity;
        logic isRead;
        logic [13:0] addr;
    } rss_cmd_s;

    typedef struct packed {
        logic [13:0] angleComp;
        logic [13:0] angleRaw;
        logic [13:0] magnitude;
        logic [13:0] diag;
    } rss_sense_s;

    typedef enum logic [0:0] {
        RSS_EXP_CMD = 1'b0,
        RSS_EXP_WDATA = 1'b1
    } rss_phase_e;

endpackage

// *** src/rss_spi_slave.sv ***
// What this block does
// R1 - Device is SPI slave only; host clock at most 10 MHz. MISO lags a rising edge by four 40 MHz clocks, too slow for 10 MHz.
// R2 - Mode 1: clock idles low, data captured on trailing edge.
// R3 - Host lowers chip select while serial clock is low.
// R4 - Each MOSI bit is captured on serial clock falling edge.
// R5 - Commands execute only at chip select rising edge, never mid-frame.
// R6 - All frames shift most significant bit first on both lines.
// R7 - Transaction is sixteen-bit command frame then sixteen-bit data frame.
// R8 - Command: bit15 even parity, bit14 read flag, bits 13..0 address.
// R9 - Bad command parity sets the parity-error flag.
// R10 - Read frame: bit15 even parity, bit14 previous error, 13..0 data.
// R11 - Read data latched at chip select rise, shifted out next frame.
// R12 - Write data frame: bit15 parity, bit14 zero, 13..0 value.
// R13 - Write: command frame then data frame with new contents.
// R14 - During write data frame return old value, then updated value.
// R15 - MISO is released after chip select rises until next select.
// R16 - Output data is marked invalid until 10 ms after power up.
// R17 - Error register: parity bit2, invalid bit1, framing bit0; read clears.
// R18 - Reading address zero has no side effect.
// R19 - Invalid register address sets the invalid-command flag.
// R20 - Non-compliant frames set the framing-error flag.
// R21 - MISO changes on rising serial clock edge.
// R22 - Bad parity or wrong-length frames leave registers unchanged.
module rss_spi_slave
    import rss_pkg::*;
#(
    parameter longint PonCycles = PON_CYCLES
)
(
    input wire logic ref_clk, // 40 MHz system clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic serialClk, // Host serial clock pin
    input wire logic chipSelectLow, // Active-low frame select pin
    input wire logic mosi, // Host data in
    output logic misoOut, // Data out value
    output logic misoOeLow, // Low while driving MISO
    input wire rss_sense_s sense, // Live sensor values
    output logic [13:0] zeroPosHi, // Soft-written zero position high
    output logic [13:0] zeroPosLo, // Soft-written zero position low
    output logic [13:0] settings1, // Custom settings 1
    output logic [13:0] settings2, // Custom settings 2
    output logic [13:0] redundancy, // Redundancy register
    output logic [13:0] progCtrl, // Programming register
    output logic [2:0] errorFlags, // Live error register
    output logic dataValid // High once power-on time elapsed
);

    logic [2:0] sckSync, csSync, mosiSync;
    logic [2:0] next_sckSync, next_csSync, next_mosiSync;
    logic sckRise, sckFall, csFall, csRise, selected;

    logic [15:0] rxShift, next_rxShift;
    logic [15:0] txShift, next_txShift;
    logic [CNT_W-1:0] bitCnt, next_bitCnt;
    logic [15:0] txWord, next_txWord;
    logic misoBit, next_misoBit;
    logic oeLow, next_oeLow;
    rss_phase_e phase, next_phase;
    logic [13:0] wrAddr, next_wrAddr;
    logic prevErr, next_prevErr;
    logic [2:0] errReg, next_errReg;
    logic [13:0] zHi, zLo, s1, s2, red, prg;
    logic [13:0] next_zHi, next_zLo, next_s1, next_s2, next_red, next_prg;
    logic [31:0] ponCnt, next_ponCnt;
    logic ponDone, next_ponDone;

    rss_cmd_s cmd;
    logic frameOk, cmdParOk;
    logic [13:0] rdVal;
    logic addrValid;
    logic sckCommit, csCommit, next_sckCommit, next_csCommit;

    assign sckRise = sckSync[1] & sckSync[2] & ~sckCommit;
    assign sckFall = ~sckSync[1] & ~sckSync[2] & sckCommit; // R2
    assign csFall = ~csSync[1] & ~csSync[2] & csCommit;
    assign csRise = csSync[1] & csSync[2] & ~csCommit;
    assign selected = ~csCommit;

    // Edges count once the second and third stages agree, so a glitch never clocks a bit.
    always_comb
    begin
        next_sckSync = {sckSync[1:0], serialClk}; // R1
        next_csSync = {csSync[1:0], chipSelectLow};
        next_mosiSync = {mosiSync[1:0], mosi};
        next_sckCommit = sckCommit;
        next_csCommit = csCommit;
        if (sckSync[1] == sckSync[2])
        begin
            next_sckCommit = sckSync[2];
        end
        if (csSync[1] == csSync[2])
        begin
            next_csCommit = csSync[2];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sckSync <= 3'h0;
            csSync <= 3'h7;
            mosiSync <= 3'h0;
            sckCommit <= 1'b0;
            csCommit <= 1'b1;
        end
        else
        begin
            sckSync <= next_sckSync;
            csSync <= next_csSync;
            mosiSync <= next_mosiSync;
            sckCommit <= next_sckCommit;
            csCommit <= next_csCommit;
        end
    end

    assign cmd = rss_cmd_s'(rxShift);
    assign cmdParOk = ~^rxShift; // R9
    assign frameOk = (bitCnt == CNT_W'(FRAME_BITS)); // R7 R20

    always_comb
    begin
        addrValid = 1'b1;
        rdVal = RST_ZERO;
        unique case (cmd.addr)
            ADDR_NOP: rdVal = RST_ZERO; // R18
            ADDR_ERRFLAGS: rdVal = {11'h000, errReg};
            ADDR_PROG: rdVal = prg;
            ADDR_ZPOS_HI: rdVal = zHi;
            ADDR_ZPOS_LO: rdVal = zLo;
            ADDR_SET1: rdVal = s1;
            ADDR_SET2: rdVal = s2;
            ADDR_REDUND: rdVal = red;
            ADDR_DIAG: rdVal = sense.diag;
            ADDR_MAGN: rdVal = sense.magnitude;
            ADDR_ANG_RAW: rdVal = sense.angleRaw;
            ADDR_ANG_COMP: rdVal = sense.angleComp;
            default: addrValid = 1'b0; // R19
        endcase
    end

    // Value of the write target, reused to echo the old contents during the data frame.
    function automatic logic [13:0] regOf(input logic [13:0] a, input logic [13:0] h,
        input logic [13:0] l, input logic [13:0] x1, input logic [13:0] x2,
        input logic [13:0] r, input logic [13:0] p);
        regOf = RST_ZERO;
        if (a == ADDR_ZPOS_HI) regOf = h;
        if (a == ADDR_ZPOS_LO) regOf = l;
        if (a == ADDR_SET1) regOf = x1;
        if (a == ADDR_SET2) regOf = x2;
        if (a == ADDR_REDUND) regOf = r;
        if (a == ADDR_PROG) regOf = p;
    endfunction

    function automatic logic [15:0] mkFrame(input logic ef, input logic [13:0] d);
        mkFrame = {^{ef, d}, ef, d}; // R10
    endfunction

    always_comb
    begin
        next_rxShift = rxShift;
        next_txShift = txShift;
        next_bitCnt = bitCnt;
        next_txWord = txWord;
        next_misoBit = misoBit;
        next_oeLow = oeLow;
        next_phase = phase;
        next_wrAddr = wrAddr;
        next_prevErr = prevErr;
        next_errReg = errReg;
        next_zHi = zHi;
        next_zLo = zLo;
        next_s1 = s1;
        next_s2 = s2;
        next_red = red;
        next_prg = prg;
        if (csFall)
        begin
            next_bitCnt = '0;
            next_txShift = txWord;
            next_misoBit = txWord[PAR_BIT]; // R6
            next_oeLow = 1'b0;
        end
        else if (selected && sckRise)
        begin
            next_misoBit = txShift[PAR_BIT]; // R21
        end
        else if (selected && sckFall)
        begin
            next_rxShift = {rxShift[14:0], mosiSync[2]}; // R4 R6
            next_txShift = {txShift[14:0], 1'b0};
            if (bitCnt != CNT_W'(FRAME_BITS + 1))
            begin
                next_bitCnt = bitCnt + CNT_W'(1);
            end
        end
        if (csRise)
        begin
            next_oeLow = 1'b1; // R15
            if (!frameOk)
            begin
                next_errReg[ERR_FRAMING] = 1'b1; // R20 R22
                next_prevErr = 1'b1;
                next_phase = RSS_EXP_CMD;
            end
            else if (phase == RSS_EXP_WDATA)
            begin
                next_phase = RSS_EXP_CMD; // R5 R13
                if (cmdParOk && !rxShift[DIR_BIT])
                begin
                    if (wrAddr == ADDR_ZPOS_HI) next_zHi = rxShift[13:0]; // R22
                    if (wrAddr == ADDR_ZPOS_LO) next_zLo = rxShift[13:0];
                    if (wrAddr == ADDR_SET1) next_s1 = rxShift[13:0];
                    if (wrAddr == ADDR_SET2) next_s2 = rxShift[13:0];
                    if (wrAddr == ADDR_REDUND) next_red = rxShift[13:0];
                    if (wrAddr == ADDR_PROG) next_prg = rxShift[13:0];
                    next_txWord = mkFrame(1'b0, rxShift[13:0]); // R14
                end
                else
                begin
                    next_errReg[ERR_FRAMING] = 1'b1;
                    next_prevErr = 1'b1;
                end
            end
            else if (!cmdParOk)
            begin
                next_errReg[ERR_PARITY] = 1'b1; // R9 R22
                next_prevErr = 1'b1;
            end
            else if (!addrValid)
            begin
                next_errReg[ERR_INVALID] = 1'b1; // R19
                next_prevErr = 1'b1;
            end
            else if (cmd.isRead)
            begin
                next_txWord = mkFrame(prevErr, rdVal); // R11 R10
                next_prevErr = 1'b0;
                if (cmd.addr == ADDR_ERRFLAGS)
                begin
                    next_errReg = 3'h0; // R17
                end
            end
            else
            begin
                next_wrAddr = cmd.addr;
                next_phase = RSS_EXP_WDATA;
                next_txWord = mkFrame(prevErr,
                    regOf(cmd.addr, zHi, zLo, s1, s2, red, prg)); // R14
                next_prevErr = 1'b0;
            end
            if (next_prevErr) next_txWord = mkFrame(1'b1, next_txWord[13:0]); // R10
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rxShift <= 16'h0000;
            txShift <= 16'h0000;
            bitCnt <= '0;
            txWord <= 16'h0000;
            misoBit <= 1'b0;
            oeLow <= 1'b1;
            phase <= RSS_EXP_CMD;
            wrAddr <= RST_ZERO;
            prevErr <= 1'b0;
            errReg <= 3'h0;
            zHi <= RST_ZERO;
            zLo <= RST_ZERO;
            s1 <= RST_SET1;
            s2 <= RST_ZERO;
            red <= RST_ZERO;
            prg <= RST_ZERO;
        end
        else
        begin
            rxShift <= next_rxShift;
            txShift <= next_txShift;
            bitCnt <= next_bitCnt;
            txWord <= next_txWord;
            misoBit <= next_misoBit;
            oeLow <= next_oeLow;
            phase <= next_phase;
            wrAddr <= next_wrAddr;
            prevErr <= next_prevErr;
            errReg <= next_errReg;
            zHi <= next_zHi;
            zLo <= next_zLo;
            s1 <= next_s1;
            s2 <= next_s2;
            red <= next_red;
            prg <= next_prg;
        end
    end

    // Power-on qualifier; the count is a parameter so a bench can shorten it.
    always_comb
    begin
        next_ponCnt = ponCnt;
        next_ponDone = ponDone;
        if (!ponDone)
        begin
            next_ponCnt = ponCnt + 32'h1;
            if (64'(ponCnt) + 64'h1 >= 64'(PonCycles))
            begin
                next_ponDone = 1'b1; // R16
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ponCnt <= 32'h0;
            ponDone <= 1'b0;
        end
        else
        begin
            ponCnt <= next_ponCnt;
            ponDone <= next_ponDone;
        end
    end

    assign misoOut = misoBit;
    assign misoOeLow = oeLow;
    assign zeroPosHi = zHi;
    assign zeroPosLo = zLo;
    assign settings1 = s1;
    assign settings2 = s2;
    assign redundancy = red;
    assign progCtrl = prg;
    assign errorFlags = errReg;
    assign dataValid = ponDone;

endmodule // rss_spi_slave
